// file: logic/mvd_value_decoder.sv
// Channel value decoder, write value former and block query planner.
//
// Notes on behaviour
// RQ1 - Inputs read holding or input space; writes holding.
// RQ2 - Register numbers span the full 16-bit range.
// RQ3 - Seven formats including IEEE single precision float.
// RQ4 - Signed formats take the top bit as sign.
// RQ5 - BCD carries two digits per byte, unsigned.
// RQ6 - 32-bit values from two registers or one.
// RQ7 - Four bytes reordered as ABCD, CDAB, DCBA, BADC.
// RQ8 - Integer and BCD values shift right, not float.
// RQ9 - Integer and BCD values are ANDed with the configured mask, not float.
// RQ10 - Remote decimal point scales by ten to minus.
// RQ11 - Over range: never, equal or differ, replaces value.
// RQ12 - Under range, waiting, error use same comparison.
// RQ13 - Lost link yields the error status.
// RQ14 - Relay writes zero or all ones of the format width.
// RQ15 - Linear writes any value inside the format range.
// RQ16 - Several registers fetched in one query.
// RQ17 - Automatic blocks never exceed the maximum size; a zero maximum is taken as one register.
// RQ18 - Order, format, shift and mask, then scale and status.
`timescale 1ns/1ps
module mvd_value_decoder
	import mvd_pkg::*;
#(
	parameter int BLK_W = 6
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Input channel configuration
	input  wire logic        cfg_in_space,
	input  wire logic [15:0] cfg_in_reg_num,
	input  wire logic [2:0]  cfg_in_format,
	input  wire logic        cfg_in_two_regs,
	input  wire logic [1:0]  cfg_in_order,
	input  wire logic [4:0]  cfg_in_shift,
	input  wire logic [31:0] cfg_in_mask,
	input  wire logic        cfg_dp_remote,
	input  wire logic [2:0]  cfg_dp_fixed,
	input  wire logic [1:0]  cfg_st_mode [NUM_STATUS],
	input  wire logic [15:0] cfg_st_value [NUM_STATUS],
	// Received register words
	input  wire logic        rx_word_valid,
	input  wire logic [2:0]  rx_word_sel,
	input  wire logic [15:0] rx_word,
	input  wire logic        rx_frame_done,
	input  wire logic        rx_comm_lost,
	// Value register read query
	output logic [7:0]       rdq_fn,
	output logic [15:0]      rdq_addr,
	output logic [1:0]       rdq_count,
	// Block planner
	input  wire logic        blk_start,
	input  wire logic        blk_manual,
	input  wire logic        blk_space,
	input  wire logic [15:0] blk_first,
	input  wire logic [15:0] blk_total,
	input  wire logic [BLK_W-1:0] blk_max,
	input  wire logic        blk_q_ready,
	output logic             blk_q_valid,
	output logic [7:0]       blk_q_fn,
	output logic [15:0]      blk_q_addr,
	output logic [15:0]      blk_q_count,
	// Channel result
	output logic             res_valid,
	output logic             res_num_valid,
	output logic             res_is_float,
	output logic [31:0]      res_data,
	output logic [15:0]      res_exp,
	output logic             over_range_status,
	output logic             under_range_status,
	output logic             res_wait,
	output logic             res_err,
	// Output channel
	input  wire logic        cfg_out_relay,
	input  wire logic [2:0]  cfg_out_format,
	input  wire logic [1:0]  cfg_out_order,
	input  wire logic        cfg_out_two_regs,
	input  wire logic [15:0] cfg_out_reg_num,
	input  wire logic        out_req,
	input  wire logic        out_level,
	input  wire logic [31:0] out_value,
	output logic             wr_valid,
	output logic [7:0]       wr_fn,
	output logic [15:0]      wr_addr,
	output logic [1:0]       wr_count,
	output logic [31:0]      wr_data
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	mvd_state_e        state_reg;
	logic [15:0]       val_upper_reg;
	logic [15:0]       val_lower_reg;
	logic [15:0]       dp_reg;
	logic [15:0]       st_word_reg [NUM_STATUS];
	logic [2:0]        fmt_snap;
	logic [1:0]        ord_snap;
	logic [4:0]        shift_snap;
	logic [31:0]       mask_snap;
	logic              dp_remote_snap;
	logic [2:0]        dp_fixed_snap;
	logic              lost_reg;
	logic [31:0]       ord_reg;
	logic [31:0]       fmt_reg;
	logic [31:0]       val_reg;
	logic [31:0]       bcd_bin;
	logic [31:0]       lin_clamped;
	logic [31:0]       lin_bcd;
	logic [31:0]       wr_next;
	logic [31:0]       shifted;
	logic [31:0]       masked;
	logic [NUM_STATUS-1:0] st_hit;
	logic              take_frame;
	logic              pl_busy_reg;
	logic              pl_manual_reg;
	logic              pl_space_reg;
	logic [15:0]       pl_addr_reg;
	logic [15:0]       pl_left_reg;
	logic [15:0]       pl_max_eff;

	assign take_frame = rx_frame_done && !rx_comm_lost &&
		(state_reg == ST_IDLE);

	// ---------------------------------------------------------------
	// Word capture and configuration snapshot
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			val_upper_reg <= RST_WORD;
			val_lower_reg <= RST_WORD;
			dp_reg        <= RST_WORD;
			for (int i = 0; i < NUM_STATUS; i++) begin
				st_word_reg[i] <= RST_WORD;
			end
		end else if (rx_word_valid) begin
			case (rx_word_sel)
				SEL_VAL_UPPER: val_upper_reg <= rx_word;
				SEL_VAL_LOWER: val_lower_reg <= rx_word;
				SEL_DEC_POINT: dp_reg <= rx_word;
				default: begin
					for (int i = 0; i < NUM_STATUS; i++) begin
						if (rx_word_sel == 3'(SEL_STATUS0 + 3'(i))) begin
							st_word_reg[i] <= rx_word;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			fmt_snap       <= FMT_S16;
			ord_snap       <= ORD_ABCD;
			shift_snap     <= 5'h00;
			mask_snap      <= ONES32;
			dp_remote_snap <= 1'b0;
			dp_fixed_snap  <= 3'h0;
		end else if (take_frame) begin
			fmt_snap       <= cfg_in_format;
			ord_snap       <= cfg_in_order;
			shift_snap     <= cfg_in_shift;
			mask_snap      <= cfg_in_mask;
			dp_remote_snap <= cfg_dp_remote;
			dp_fixed_snap  <= cfg_dp_fixed;
		end
	end

	// ---------------------------------------------------------------
	// Value read query
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdq_fn    <= FN_READ_HOLD;
			rdq_addr  <= RST_WORD;
			rdq_count <= 2'h1;
		end else begin
			rdq_fn    <= cfg_in_space ? FN_READ_INPUT : FN_READ_HOLD; // [RQ1]
			rdq_addr  <= cfg_in_reg_num; // [RQ2]
			rdq_count <= (mvd_is32(cfg_in_format) && cfg_in_two_regs) ?
				2'h2 : 2'h1; // [RQ6]
		end
	end

	// ---------------------------------------------------------------
	// Decode pipeline
	// ---------------------------------------------------------------
	mvd_bcd_conv #(
		.DIGITS (8)
	) u_bcd (
		.bcd_in  (ord_reg),
		.bin_out (bcd_bin),
		.bin_in  (lin_clamped),
		.bcd_out (lin_bcd)
	);

	always_comb begin
		if (mvd_is32(fmt_snap)) begin
			shifted = fmt_reg >> shift_snap; // [RQ8]
			masked  = shifted & mask_snap; // [RQ9]
		end else begin
			shifted = {16'h0000, fmt_reg[15:0] >> shift_snap[3:0]}; // [RQ8]
			masked  = shifted & {16'h0000, mask_snap[15:0]}; // [RQ9]
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_STATUS; g++) begin : g_status
			mvd_status_cmp u_cmp (
				.cmp_mode  (cfg_st_mode[g]),
				.cmp_value (cfg_st_value[g]),
				.cmp_word  (st_word_reg[g]),
				.cmp_hit   (st_hit[g])
			); // [RQ11] [RQ12]
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			lost_reg  <= 1'b0;
		end else if (rx_comm_lost) begin
			state_reg <= ST_EMIT;
			lost_reg  <= 1'b1; // [RQ13]
		end else begin
			case (state_reg)
				ST_IDLE:   state_reg <= take_frame ? ST_ORDER : ST_IDLE;
				ST_ORDER:  state_reg <= ST_FORMAT;
				ST_FORMAT: state_reg <= ST_SHIFT;
				ST_SHIFT:  state_reg <= ST_EMIT; // [RQ18]
				ST_EMIT: begin
					state_reg <= ST_IDLE;
					lost_reg  <= 1'b0;
				end
				default:   state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ord_reg <= RST_DWORD;
			fmt_reg <= RST_DWORD;
			val_reg <= RST_DWORD;
		end else begin
			if (state_reg == ST_ORDER) begin
				ord_reg <= mvd_is32(fmt_snap) ?
					mvd_reorder({val_upper_reg, val_lower_reg},
					ord_snap) : {16'h0000, val_upper_reg}; // [RQ7]
			end
			if (state_reg == ST_FORMAT) begin
				fmt_reg <= (fmt_snap == FMT_BCD16 ||
					fmt_snap == FMT_BCD32) ? bcd_bin : ord_reg; // [RQ5]
			end
			if (state_reg == ST_SHIFT) begin
				case (fmt_snap)
					FMT_F32: val_reg <= fmt_reg; // [RQ3]
					FMT_S16: val_reg <= {{16{masked[15]}},
						masked[15:0]}; // [RQ4]
					default: val_reg <= masked;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			res_valid          <= 1'b0;
			res_num_valid      <= 1'b0;
			res_is_float       <= 1'b0;
			res_data           <= RST_DWORD;
			res_exp            <= RST_WORD;
			over_range_status  <= 1'b0;
			under_range_status <= 1'b0;
			res_wait           <= 1'b0;
			res_err            <= 1'b0;
		end else begin
			res_valid <= (state_reg == ST_EMIT) && !rx_comm_lost;
			if ((state_reg == ST_EMIT) && !rx_comm_lost) begin
				res_err            <= st_hit[STI_ERR] || lost_reg; // [RQ13]
				over_range_status  <= st_hit[STI_OVER] && !lost_reg; // [RQ11]
				under_range_status <= st_hit[STI_UNDER] && !lost_reg; // [RQ12]
				res_wait           <= st_hit[STI_WAIT] && !lost_reg;
				res_num_valid      <= !(lost_reg || (|st_hit)); // [RQ11]
				res_is_float       <= (fmt_snap == FMT_F32);
				res_data           <= (lost_reg || (|st_hit)) ?
					RST_DWORD : val_reg;
				res_exp            <= dp_remote_snap ?
					16'h0000 - dp_reg :
					16'h0000 - {13'h0000, dp_fixed_snap}; // [RQ10]
			end
		end
	end

	// ---------------------------------------------------------------
	// Output channel write value
	// ---------------------------------------------------------------
	always_comb begin
		lin_clamped = out_value;
		case (cfg_out_format)
			FMT_S16: begin
				if ($signed(out_value) > $signed(S16_MAX)) begin
					lin_clamped = S16_MAX;
				end else if ($signed(out_value) < $signed(S16_MIN)) begin
					lin_clamped = S16_MIN;
				end
			end
			FMT_U16: begin
				if (out_value[31]) begin
					lin_clamped = RST_DWORD;
				end else if (out_value > ONES16) begin
					lin_clamped = ONES16;
				end
			end
			FMT_U32: lin_clamped = out_value[31] ? RST_DWORD : out_value;
			FMT_BCD16: begin
				if (out_value[31]) begin
					lin_clamped = RST_DWORD;
				end else if (out_value > BCD16_MAX) begin
					lin_clamped = BCD16_MAX;
				end
			end
			FMT_BCD32: begin
				if (out_value[31]) begin
					lin_clamped = RST_DWORD;
				end else if (out_value > BCD32_MAX) begin
					lin_clamped = BCD32_MAX;
				end
			end
			default: lin_clamped = out_value;
		endcase
	end

	always_comb begin
		if (cfg_out_relay) begin
			wr_next = out_level ? (mvd_is32(cfg_out_format) ?
				ONES32 : ONES16) : RST_DWORD; // [RQ14]
		end else if (cfg_out_format == FMT_BCD16 ||
			cfg_out_format == FMT_BCD32) begin
			wr_next = lin_bcd; // [RQ5]
		end else if (mvd_is32(cfg_out_format)) begin
			wr_next = lin_clamped; // [RQ15]
		end else begin
			wr_next = {16'h0000, lin_clamped[15:0]}; // [RQ15]
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_valid <= 1'b0;
			wr_fn    <= FN_WRITE_MULTI;
			wr_addr  <= RST_WORD;
			wr_count <= 2'h1;
			wr_data  <= RST_DWORD;
		end else begin
			wr_valid <= out_req;
			if (out_req) begin
				wr_fn    <= FN_WRITE_MULTI; // [RQ1]
				wr_addr  <= cfg_out_reg_num; // [RQ2]
				wr_count <= (mvd_is32(cfg_out_format) && cfg_out_two_regs) ?
					2'h2 : 2'h1; // [RQ6]
				wr_data  <= mvd_is32(cfg_out_format) ?
					mvd_reorder(wr_next, cfg_out_order) : wr_next; // [RQ7]
			end
		end
	end

	// ---------------------------------------------------------------
	// Block query planner
	// ---------------------------------------------------------------
	assign pl_max_eff = (blk_max == '0) ? 16'h0001 :
		{{(16-BLK_W){1'b0}}, blk_max};
	assign blk_q_valid = pl_busy_reg;
	assign blk_q_fn    = pl_space_reg ? FN_READ_INPUT : FN_READ_HOLD;
	assign blk_q_addr  = pl_addr_reg;
	assign blk_q_count = (pl_manual_reg || pl_left_reg <= pl_max_eff) ?
		pl_left_reg : pl_max_eff; // [RQ17]

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pl_busy_reg   <= 1'b0;
			pl_manual_reg <= 1'b0;
			pl_space_reg  <= 1'b0;
			pl_addr_reg   <= RST_WORD;
			pl_left_reg   <= RST_WORD;
		end else if (!pl_busy_reg) begin
			if (blk_start && blk_total != RST_WORD) begin
				pl_busy_reg   <= 1'b1;
				pl_manual_reg <= blk_manual;
				pl_space_reg  <= blk_space;
				pl_addr_reg   <= blk_first;
				pl_left_reg   <= blk_total;
			end
		end else if (blk_q_ready) begin
			pl_addr_reg <= pl_addr_reg + blk_q_count; // [RQ16]
			pl_left_reg <= pl_left_reg - blk_q_count;
			pl_busy_reg <= (pl_left_reg != blk_q_count);
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_frame_taken;
		take_frame ##1 (!rx_comm_lost)[*4];
	endsequence

	sequence s_link_lost;
		rx_comm_lost ##1 !rx_comm_lost;
	endsequence

	a_read_space: assert property (##1 rdq_fn == ($past(cfg_in_space) ?
		FN_READ_INPUT : FN_READ_HOLD)) // [RQ1]
		else $error("read function wrong");
	a_pipe_order: assert property (s_frame_taken |-> ##1 res_valid) // [RQ18]
		else $error("result late");
	a_lost_error: assert property (s_link_lost |-> ##1 (res_valid &&
		res_err && !res_num_valid)) // [RQ13]
		else $error("no error on lost link");
	a_over_replace: assert property (res_valid && over_range_status |->
		!res_num_valid && res_data == RST_DWORD) // [RQ11]
		else $error("status kept value");
	a_mask_zero: assert property (res_valid && res_num_valid &&
		!res_is_float && mask_snap == RST_DWORD |-> res_data == RST_DWORD) // [RQ9]
		else $error("zero mask kept value");
	a_sign_extend: assert property (res_valid && res_num_valid &&
		fmt_snap == FMT_S16 |-> res_data[31:16] == {16{res_data[15]}}) // [RQ4]
		else $error("no sign extension");
	a_remote_exp: assert property (res_valid && res_num_valid &&
		dp_remote_snap |-> res_exp == 16'h0000 - $past(dp_reg)) // [RQ10]
		else $error("exponent wrong");
	a_relay_value: assert property (wr_valid && $past(cfg_out_relay) |->
		wr_data == RST_DWORD || wr_data == ONES16 ||
		wr_data == ONES32) // [RQ14]
		else $error("relay value wrong");
	a_block_limit: assert property (blk_q_valid && !pl_manual_reg |->
		blk_q_count != RST_WORD && blk_q_count <= pl_max_eff) // [RQ17]
		else $error("block too large");
	a_block_step: assert property (blk_q_valid && blk_q_ready ##1
		blk_q_valid |-> blk_q_addr == 16'($past(blk_q_addr) +
		$past(blk_q_count))) // [RQ16]
		else $error("block address wrong");

endmodule

// file: logic/mvd_pkg.sv
// Shared constants, types and helpers of the channel value decoder.
package mvd_pkg;

	// ---------------------------------------------------------------
	// Value formats and byte orders
	// ---------------------------------------------------------------
	localparam logic [2:0] FMT_S16   = 3'h0;
	localparam logic [2:0] FMT_U16   = 3'h1;
	localparam logic [2:0] FMT_S32   = 3'h2;
	localparam logic [2:0] FMT_U32   = 3'h3;
	localparam logic [2:0] FMT_F32   = 3'h4;
	localparam logic [2:0] FMT_BCD16 = 3'h5;
	localparam logic [2:0] FMT_BCD32 = 3'h6;
	localparam logic [1:0] ORD_ABCD  = 2'h0;
	localparam logic [1:0] ORD_CDAB  = 2'h1;
	localparam logic [1:0] ORD_DCBA  = 2'h2;
	localparam logic [1:0] ORD_BADC  = 2'h3;

	// ---------------------------------------------------------------
	// Status comparison modes and status indices
	// ---------------------------------------------------------------
	localparam logic [1:0] CMP_NEVER  = 2'h0;
	localparam logic [1:0] CMP_EQUAL  = 2'h1;
	localparam logic [1:0] CMP_DIFFER = 2'h2;
	localparam int         NUM_STATUS = 4;
	localparam int         STI_OVER   = 0;
	localparam int         STI_UNDER  = 1;
	localparam int         STI_WAIT   = 2;
	localparam int         STI_ERR    = 3;

	// ---------------------------------------------------------------
	// Function codes, word selectors, limits and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  FN_READ_HOLD   = 8'h03;
	localparam logic [7:0]  FN_READ_INPUT  = 8'h04;
	localparam logic [7:0]  FN_WRITE_MULTI = 8'h10;
	localparam logic [2:0]  SEL_VAL_UPPER  = 3'h0;
	localparam logic [2:0]  SEL_VAL_LOWER  = 3'h1;
	localparam logic [2:0]  SEL_DEC_POINT  = 3'h2;
	localparam logic [2:0]  SEL_STATUS0    = 3'h3;
	localparam logic [15:0] RST_WORD       = 16'h0000;
	localparam logic [31:0] RST_DWORD      = 32'h00000000;
	localparam logic [31:0] ONES16         = 32'h0000FFFF;
	localparam logic [31:0] ONES32         = 32'hFFFFFFFF;
	localparam logic [31:0] S16_MAX        = 32'h00007FFF;
	localparam logic [31:0] S16_MIN        = 32'hFFFF8000;
	localparam logic [31:0] BCD16_MAX      = 32'h0000270F;
	localparam logic [31:0] BCD32_MAX      = 32'h05F5E0FF;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_ORDER  = 3'b001,
		ST_FORMAT = 3'b010,
		ST_SHIFT  = 3'b011,
		ST_EMIT   = 3'b100
	} mvd_state_e;

	// True for every format that occupies four bytes.
	function automatic logic mvd_is32(input logic [2:0] fmt);
		return (fmt == FMT_S32) || (fmt == FMT_U32) ||
			(fmt == FMT_F32) || (fmt == FMT_BCD32);
	endfunction

	// Reorders bytes A B C D; every order is its own inverse.
	function automatic logic [31:0] mvd_reorder(input logic [31:0] w,
		input logic [1:0] ord);
		case (ord)
			ORD_CDAB: return {w[15:0], w[31:16]};
			ORD_DCBA: return {w[7:0], w[15:8], w[23:16], w[31:24]};
			ORD_BADC: return {w[23:16], w[31:24], w[7:0], w[15:8]};
			default:  return w;
		endcase
	endfunction

endpackage

// file: logic/mvd_status_cmp.sv
// Never, equal or differ comparison of one status register.
`timescale 1ns/1ps
module mvd_status_cmp
	import mvd_pkg::*;
(
	// Configuration
	input  wire logic [1:0]  cmp_mode,
	input  wire logic [15:0] cmp_value,
	// Status word and result
	input  wire logic [15:0] cmp_word,
	output logic             cmp_hit
);

	always_comb begin
		case (cmp_mode)
			CMP_EQUAL:  cmp_hit = (cmp_word == cmp_value);
			CMP_DIFFER: cmp_hit = (cmp_word != cmp_value);
			default:    cmp_hit = 1'b0;
		endcase
	end

endmodule

// file: logic/mvd_bcd_conv.sv
// Packed BCD to binary and binary to packed BCD converters.
`timescale 1ns/1ps
module mvd_bcd_conv #(
	parameter int DIGITS = 8
) (
	// Packed BCD in, binary out
	input  wire logic [4*DIGITS-1:0] bcd_in,
	output logic [31:0]              bin_out,
	// Binary in, packed BCD out
	input  wire logic [31:0]         bin_in,
	output logic [4*DIGITS-1:0]      bcd_out
);

	logic [31:0]            acc;
	logic [4*DIGITS+31:0]   sh;

	// Two digits per byte, most significant digit first.
	always_comb begin
		acc = 32'h00000000;
		for (int i = DIGITS - 1; i >= 0; i--) begin
			acc = 32'(acc * 32'd10) + {28'h0000000, bcd_in[4*i +: 4]};
		end
		bin_out = acc;
	end

	// Shift-and-add-three conversion of the binary value.
	always_comb begin
		sh = {{(4*DIGITS){1'b0}}, bin_in};
		for (int i = 0; i < 32; i++) begin
			for (int d = 0; d < DIGITS; d++) begin
				if (sh[32+4*d +: 4] >= 4'h5) begin
					sh[32+4*d +: 4] = sh[32+4*d +: 4] + 4'h3;
				end
			end
			sh = sh << 1;
		end
		bcd_out = sh[4*DIGITS+31:32];
	end

endmodule

// file: testbench/mvd_slave_model.sv
// Behavioural slave device that answers a value read word by word.
`timescale 1ns/1ps
module mvd_slave_model
	import mvd_pkg::*;
(
	// Clock, reset and pacing
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        go,
	input  wire logic        slow,
	// Query function and register banks
	input  wire logic [7:0]  fn,
	input  wire logic [15:0] hold_w [7],
	input  wire logic [15:0] inp_w [7],
	// Answer words
	output logic             rx_word_valid,
	output logic [2:0]       rx_word_sel,
	output logic [15:0]      rx_word,
	output logic             rx_frame_done
);
	logic       busy_reg;
	logic       gap_reg;
	logic [2:0] idx_reg;

	// Idle data toggles so stale words never look valid.
	always_ff @(posedge clk_sys) begin
		rx_word_valid <= 1'h0;
		rx_frame_done <= 1'h0;
		if (rst) begin
			busy_reg <= 1'h0;
			gap_reg <= 1'h0;
			idx_reg <= 3'h0;
			rx_word_sel <= 3'h0;
			rx_word <= 16'h0000;
		end else if (!busy_reg) begin
			rx_word <= ~rx_word;
			busy_reg <= go;
			idx_reg <= 3'h0;
			gap_reg <= 1'h0;
		end else if (slow && !gap_reg) begin
			gap_reg <= 1'h1;
			rx_word <= ~rx_word;
		end else if (idx_reg == 3'h7) begin
			rx_frame_done <= 1'h1;
			busy_reg <= 1'h0;
		end else begin
			gap_reg <= 1'h0;
			rx_word_valid <= 1'h1;
			rx_word_sel <= idx_reg;
			rx_word <= (fn == FN_READ_INPUT) ? inp_w[idx_reg] : hold_w[idx_reg];
			idx_reg <= idx_reg + 3'h1;
		end
	end
endmodule

// file: testbench/test_mvd_value_decoder.sv
// Self-checking bench of the channel value decoder.
`timescale 1ns/1ps
`define CK(g, e) check(32'(g), 32'(e))
module test_mvd_value_decoder
	import mvd_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clk_sys = 1'h0, rst = 1'h1, go = 1'h0, slow = 1'h0;
	logic        cfg_in_space = 1'h0, cfg_in_two_regs = 1'h1;
	logic        cfg_dp_remote = 1'h0, rx_comm_lost = 1'h0;
	logic [15:0] cfg_in_reg_num = 16'h0000;
	logic [2:0]  cfg_in_format = FMT_U32, cfg_dp_fixed = 3'h0;
	logic [1:0]  cfg_in_order = ORD_ABCD;
	logic [4:0]  cfg_in_shift = 5'h0;
	logic [31:0] cfg_in_mask = ONES32;
	logic [1:0]  cfg_st_mode [NUM_STATUS] = '{default: CMP_NEVER};
	logic [15:0] cfg_st_value [NUM_STATUS] = '{default: 16'h0000};
	logic [15:0] hw [7] = '{default: 16'h0000};
	logic [15:0] iw [7] = '{default: 16'h0000};
	logic        rx_word_valid, rx_frame_done;
	logic [2:0]  rx_word_sel;
	logic [15:0] rx_word, rdq_addr, blk_q_addr, blk_q_count, res_exp, wr_addr;
	logic [7:0]  rdq_fn, blk_q_fn, wr_fn;
	logic [1:0]  rdq_count, wr_count;
	logic        blk_start = 1'h0, blk_manual = 1'h0, blk_space = 1'h0;
	logic        blk_q_ready = 1'h0;
	logic [15:0] blk_first = 16'h0100, blk_total = 16'h000A;
	logic [5:0]  blk_max = 6'h04;
	logic        blk_q_valid, res_valid, res_num_valid, res_is_float;
	logic        over_range_status, under_range_status, res_wait, res_err;
	logic [31:0] res_data, wr_data;
	logic        cfg_out_relay = 1'h0, cfg_out_two_regs = 1'h0;
	logic        out_req = 1'h0, out_level = 1'h0, wr_valid;
	logic [2:0]  cfg_out_format = FMT_U16;
	logic [1:0]  cfg_out_order = ORD_ABCD;
	logic [15:0] cfg_out_reg_num = 16'hFFFF;
	logic [31:0] out_value = 32'h00000000;
	int          failures = 0, total_checks = 0, cycles = 0;

	mvd_value_decoder #(.BLK_W(6)) dut (.*);

	mvd_slave_model partner (.*, .fn(rdq_fn), .hold_w(hw), .inp_w(iw));

	always #2 clk_sys = ~clk_sys;

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic wrap_up();
		$display("Checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic run_frame();
		int n;
		n = 0;
		@(posedge clk_sys);
		go <= 1'h1;
		@(posedge clk_sys);
		go <= 1'h0;
		while (rx_frame_done !== 1'h1 && n < 100) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		repeat (5) @(posedge clk_sys);
		#1;
		`CK(res_valid, 1'h1);
	endtask

	task automatic decode(input logic [2:0] f, input logic [1:0] o,
		input logic [31:0] w, input int sh, input logic [31:0] mk, ex);
		@(posedge clk_sys);
		cfg_in_format <= f;
		cfg_in_order <= o;
		cfg_in_shift <= 5'(sh);
		cfg_in_mask <= mk;
		{hw[0], hw[1]} <= w;
		{iw[0], iw[1]} <= w;
		run_frame();
		`CK(res_data, ex);
	endtask

	task automatic wr(input logic rl, lv, input logic [2:0] f,
		input logic [1:0] o, input logic two, input logic [31:0] v, ex,
		input logic [1:0] cnt);
		@(posedge clk_sys);
		cfg_out_relay <= rl;
		out_level <= lv;
		cfg_out_format <= f;
		cfg_out_order <= o;
		cfg_out_two_regs <= two;
		out_value <= v;
		out_req <= 1'h1;
		@(posedge clk_sys);
		out_req <= 1'h0;
		#1;
		`CK(wr_valid, 1'h1);
		`CK(wr_data, ex);
		`CK(wr_count, cnt);
		`CK(wr_fn, FN_WRITE_MULTI);
		`CK(wr_addr, 16'hFFFF);
	endtask

	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'h0;
		cfg_in_reg_num <= 16'hFFFF;
		cfg_in_space <= 1'h1;
		repeat (2) @(posedge clk_sys);
		#1;
		`CK(rdq_addr, 16'hFFFF);
		`CK(rdq_fn, FN_READ_INPUT);
		`CK(rdq_count, 2'h2);
		cfg_in_reg_num <= 16'h0000;
		cfg_in_space <= 1'h0;
		cfg_in_two_regs <= 1'h0;
		repeat (2) @(posedge clk_sys);
		#1;
		`CK(rdq_addr, 16'h0000);
		`CK(rdq_fn, FN_READ_HOLD);
		`CK(rdq_count, 2'h1);
		$display("Read query test done");
		decode(FMT_S16, ORD_ABCD, 32'hFFFE0000, 0, ONES32, 32'hFFFFFFFE);
		decode(FMT_U16, ORD_ABCD, 32'hFFFE0000, 0, ONES32, 32'h0000FFFE);
		decode(FMT_U32, ORD_ABCD, 32'h12345678, 0, ONES32, 32'h12345678);
		decode(FMT_U32, ORD_CDAB, 32'h12345678, 0, ONES32, 32'h56781234);
		decode(FMT_U32, ORD_DCBA, 32'h12345678, 0, ONES32, 32'h78563412);
		decode(FMT_U32, ORD_BADC, 32'h12345678, 0, ONES32, 32'h34127856);
		decode(FMT_F32, ORD_ABCD, 32'h3F800000, 4, 32'h0, 32'h3F800000);
		`CK(res_is_float, 1'h1);
		decode(FMT_BCD16, ORD_ABCD, 32'h12340000, 0, ONES32, 32'h4D2);
		decode(FMT_BCD32, ORD_ABCD, 32'h00123456, 0, ONES32, 32'h1E240);
		decode(FMT_U16, ORD_ABCD, 32'hABCD0000, 4, 32'hF0, 32'hB0);
		decode(FMT_U16, ORD_ABCD, 32'h80000000, 15, ONES32, 32'h1);
		decode(FMT_S32, ORD_ABCD, 32'h80000000, 31, ONES32, 32'h1);
		decode(FMT_U16, ORD_ABCD, 32'hFFFF0000, 0, 32'h0, 32'h0);
		`CK(res_exp, 16'h0000);
		cfg_dp_fixed <= 3'h2;
		decode(FMT_U16, ORD_ABCD, 32'h00070000, 0, ONES32, 32'h7);
		`CK(res_exp, 16'hFFFE);
		cfg_dp_remote <= 1'h1;
		hw[2] <= 16'h0003;
		decode(FMT_U16, ORD_ABCD, 32'h00070000, 0, ONES32, 32'h7);
		`CK(res_exp, 16'hFFFD);
		cfg_in_space <= 1'h1;
		iw[0] <= 16'h2222;
		run_frame();
		`CK(res_data, 32'h2222);
		$display("Decode test done");
		slow <= 1'h1;
		for (int i = 0; i < NUM_STATUS; i++) begin
			for (int m = 0; m < 3; m++) begin
				@(posedge clk_sys);
				iw[3 + i] <= 16'h00A5;
				cfg_st_mode[i] <= 2'(m);
				cfg_st_value[i] <= (m == 2) ? 16'h005A : 16'h00A5;
				run_frame();
				`CK({res_err, res_wait, under_range_status, over_range_status}, (m != 0) ? (32'h1 << i) : 32'h0);
				`CK(res_num_valid, m == 0);
				`CK(res_data, (m == 0) ? 32'h2222 : 32'h0);
			end
			cfg_st_mode[i] <= CMP_NEVER;
		end
		@(posedge clk_sys);
		rx_comm_lost <= 1'h1;
		@(posedge clk_sys);
		rx_comm_lost <= 1'h0;
		for (int n = 0; n < 4 && res_valid !== 1'h1; n++)
			@(posedge clk_sys) #1;
		`CK(res_valid, 1'h1);
		`CK(res_err, 1'h1);
		`CK(res_num_valid, 1'h0);
		`CK(res_data, 32'h0);
		$display("Status test done");
		wr(1'h1, 1'h0, FMT_U16, ORD_ABCD, 1'h0, 32'h1, 32'h0, 2'h1);
		wr(1'h1, 1'h1, FMT_U16, ORD_ABCD, 1'h0, 32'h0, 32'hFFFF, 2'h1);
		wr(1'h1, 1'h1, FMT_U32, ORD_ABCD, 1'h1, 32'h0, ONES32, 2'h2);
		wr(1'h0, 1'h0, FMT_U16, ORD_ABCD, 1'h0, 32'h11170, 32'hFFFF, 2'h1);
		wr(1'h0, 1'h0, FMT_S16, ORD_ABCD, 1'h0, -32'sd5, 32'hFFFB, 2'h1);
		wr(1'h0, 1'h0, FMT_BCD16, ORD_ABCD, 1'h0, 32'd1234, 32'h1234, 2'h1);
		wr(1'h0, 1'h0, FMT_U32, ORD_CDAB, 1'h1, 32'h12345678, 32'h56781234, 2'h2);
		wr(1'h0, 1'h0, FMT_U32, ORD_ABCD, 1'h1, 32'h80000000, 32'h0, 2'h2);
		$display("Output write test done");
		for (int m = 0; m < 2; m++) begin
			int left, addr, c;
			left = 10;
			addr = 16'h0100;
			@(posedge clk_sys);
			blk_manual <= 1'(m);
			blk_space <= 1'(m);
			blk_start <= 1'h1;
			blk_q_ready <= 1'h1;
			@(posedge clk_sys);
			blk_start <= 1'h0;
			while (left > 0) begin
				c = (m == 1 || left < 4) ? left : 4;
				#1;
				`CK(blk_q_valid, 1'h1);
				`CK(blk_q_fn, m ? FN_READ_INPUT : FN_READ_HOLD);
				`CK({blk_q_addr, blk_q_count}, {16'(addr), 16'(c)});
				left -= c;
				addr += c;
				@(posedge clk_sys);
			end
			#1;
			`CK(blk_q_valid, 1'h0);
		end
		$display("Block planner test done");
		wrap_up();
	end
endmodule
